// >>> src/miec_map.vh
`ifndef MIEC_MAP_VH
`define MIEC_MAP_VH
// clocks per instruction cycle
`define MIEC_CLK_PER_ICYC   3'h4
// operation codes on op_in
`define MIEC_OP_NOP    5'h00
`define MIEC_OP_MOVRA  5'h01
`define MIEC_OP_MOVAR  5'h02
`define MIEC_OP_MOVIA  5'h03
`define MIEC_OP_ADD    5'h04
`define MIEC_OP_SUB    5'h05
`define MIEC_OP_AND    5'h06
`define MIEC_OP_OR     5'h07
`define MIEC_OP_XOR    5'h08
`define MIEC_OP_CPL    5'h09
`define MIEC_OP_INC    5'h0a
`define MIEC_OP_DEC    5'h0b
`define MIEC_OP_RL     5'h0c
`define MIEC_OP_RR     5'h0d
`define MIEC_OP_RLC    5'h0e
`define MIEC_OP_RRC    5'h0f
`define MIEC_OP_SETB   5'h10
`define MIEC_OP_CLRB   5'h11
`define MIEC_OP_SZ     5'h12
`define MIEC_OP_SNZ    5'h13
`define MIEC_OP_SZB    5'h14
`define MIEC_OP_SNZB   5'h15
`define MIEC_OP_JMP    5'h16
`define MIEC_OP_CALL   5'h17
`define MIEC_OP_RET    5'h18
`define MIEC_OP_RETI   5'h19
`define MIEC_OP_TABRD  5'h1a
`define MIEC_OP_WRPCL  5'h1b
// last clock of an instruction cycle, where execute happens
`define MIEC_LAST_PHASE  2'h3
// pc step for a taken skip: over one instruction
`define MIEC_SKIP_STEP   11'h002
// reset values
`define MIEC_PC_RST    11'h000
`define MIEC_BYTE_RST  8'h00
`define MIEC_FLAG_RST  1'b0
`define MIEC_PHASE_RST 2'h0
`define MIEC_SP_RST    2'h0
`define MIEC_STACK_DEPTH 4
`endif

// >>> src/miec_core.v
`include "miec_map.vh"

// Overview of operation
// - instruction cycle is four clocks
// - branch call return table read take two
// - low pc byte write jumps, extra cycle
// - taken skip adds one cycle
// - test byte or bit, maybe skip next
// - logic ops set zero on zero
// - add carry over 255, subtract carry on no borrow
// - increment and decrement by exactly one
// - rotate left or right, with/without carry
// - through-carry rotate puts bit in carry
// - call saves return, return resumes after
// - jump loads target without saving return
// - bit set/clear changes only that bit
// - table read fetches program memory constant
// - three data move transfers supported
// - return from interrupt sets interrupt enable
module miec_core (
  // clock, reset, enable
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        ce_in,
  // instruction and operands
  input  wire [4:0]  op_in,
  input  wire [7:0]  mem_rd_in,
  input  wire [7:0]  imm_in,
  input  wire [2:0]  bit_sel_in,
  input  wire [10:0] addr_in,
  input  wire [7:0]  table_data_in,
  // state outputs
  output reg  [10:0] pc_out,
  output reg  [7:0]  acc_out,
  output reg  [7:0]  mem_wr_data_out,
  output reg         mem_wr_out,
  output reg         zero_out,
  output reg         carry_out,
  output reg         global_interrupt_enable_out,
  output reg  [7:0]  table_latch_out,
  output reg         fetch_out,
  output reg  [1:0]  phase_out,
  output reg         stall_out
);

  // sequencing states; the wait state burns the extra instruction cycle
  // and ignores the instruction inputs through its final clock
  localparam ST_EXEC = 1'b0;
  localparam ST_WAIT = 1'b1;

  // operation needing a second instruction cycle, no skip
  function is_two_cycle;
    input [4:0] op;
    begin
      is_two_cycle = (op == `MIEC_OP_JMP) || (op == `MIEC_OP_CALL) ||
                     (op == `MIEC_OP_RET) || (op == `MIEC_OP_RETI) ||
                     (op == `MIEC_OP_TABRD) || (op == `MIEC_OP_WRPCL);
    end
  endfunction

  // single bit mask from index
  function [7:0] bit_mask;
    input [2:0] idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  // call stack, pointer and sequencing state
  // the stack wraps silently, a fifth nested call loses the oldest return
  reg  [10:0] stack_q [0:`MIEC_STACK_DEPTH-1];
  reg  [1:0]  sp_q;
  reg         state_q;
  // next values from the execute decode
  reg  [10:0] pc_d;
  reg  [7:0]  acc_d;
  reg  [7:0]  wr_d;
  reg         wr_en_d;
  reg         z_d;
  reg         c_d;
  reg         gie_d;
  reg  [7:0]  tbl_d;
  reg         extra_d;
  reg         push_d;
  reg         pop_d;
  // decode scratch values
  reg  [8:0]  sum;
  reg         bitval;
  // sequencing helpers
  wire [10:0] pc_inc;
  wire        icyc_end;
  integer     k;

  // next sequential address and cycle boundary
  assign pc_inc   = pc_out + 11'h001;
  assign icyc_end = (phase_out == `MIEC_LAST_PHASE);

  // execute decode, evaluated at the last phase of a cycle
  always @* begin
    // defaults hold every result and step the pc to pc_inc, so unlisted codes act as no operation
    pc_d    = pc_inc;
    acc_d   = acc_out;
    wr_d    = mem_wr_data_out;
    wr_en_d = 1'b0;
    z_d     = zero_out;
    c_d     = carry_out;
    gie_d   = global_interrupt_enable_out;
    tbl_d   = table_latch_out;
    extra_d = is_two_cycle(op_in);
    push_d  = 1'b0;
    pop_d   = 1'b0;
    sum     = 9'h000;
    bitval  = mem_rd_in[bit_sel_in];
    case (op_in)
      // data moves
      `MIEC_OP_MOVRA: acc_d = mem_rd_in;
      `MIEC_OP_MOVAR: begin
        wr_d    = acc_out;
        wr_en_d = 1'b1;
      end
      `MIEC_OP_MOVIA: acc_d = imm_in;

      // arithmetic into the accumulator; carry set means no borrow
      `MIEC_OP_ADD: begin
        sum   = {1'b0, acc_out} + {1'b0, mem_rd_in};
        acc_d = sum[7:0];
        c_d   = sum[8];
        z_d   = (sum[7:0] == 8'h00);
      end
      `MIEC_OP_SUB: begin
        sum   = {1'b0, acc_out} - {1'b0, mem_rd_in};
        acc_d = sum[7:0];
        c_d   = ~sum[8];
        z_d   = (sum[7:0] == 8'h00);
      end

      // logic into the accumulator
      `MIEC_OP_AND: begin
        acc_d = acc_out & mem_rd_in;
        z_d   = ((acc_out & mem_rd_in) == 8'h00);
      end
      `MIEC_OP_OR: begin
        acc_d = acc_out | mem_rd_in;
        z_d   = ((acc_out | mem_rd_in) == 8'h00);
      end
      `MIEC_OP_XOR: begin
        acc_d = acc_out ^ mem_rd_in;
        z_d   = ((acc_out ^ mem_rd_in) == 8'h00);
      end

      // complement, increment and decrement write memory
      `MIEC_OP_CPL: begin
        wr_d    = ~mem_rd_in;
        wr_en_d = 1'b1;
        z_d     = (mem_rd_in == 8'hff);
      end
      `MIEC_OP_INC: begin
        wr_d    = mem_rd_in + 8'h01;
        wr_en_d = 1'b1;
        z_d     = (mem_rd_in == 8'hff);
      end
      `MIEC_OP_DEC: begin
        wr_d    = mem_rd_in - 8'h01;
        wr_en_d = 1'b1;
        z_d     = (mem_rd_in == 8'h01);
      end

      // rotates within the byte and through the carry
      `MIEC_OP_RL: begin
        wr_d    = {mem_rd_in[6:0], mem_rd_in[7]};
        wr_en_d = 1'b1;
      end
      `MIEC_OP_RR: begin
        wr_d    = {mem_rd_in[0], mem_rd_in[7:1]};
        wr_en_d = 1'b1;
      end
      `MIEC_OP_RLC: begin
        wr_d    = {mem_rd_in[6:0], carry_out};
        wr_en_d = 1'b1;
        c_d     = mem_rd_in[7];
      end
      `MIEC_OP_RRC: begin
        wr_d    = {carry_out, mem_rd_in[7:1]};
        wr_en_d = 1'b1;
        c_d     = mem_rd_in[0];
      end

      // single bit set and clear as one read-modify-write
      `MIEC_OP_SETB: begin
        wr_d    = mem_rd_in | bit_mask(bit_sel_in);
        wr_en_d = 1'b1;
      end
      `MIEC_OP_CLRB: begin
        wr_d    = mem_rd_in & ~bit_mask(bit_sel_in);
        wr_en_d = 1'b1;
      end

      // conditional skips step over the next instruction
      // a taken skip also costs one extra instruction cycle
      `MIEC_OP_SZ: begin
        extra_d = (mem_rd_in == 8'h00);
        pc_d    = extra_d ? pc_out + `MIEC_SKIP_STEP : pc_inc;
      end
      `MIEC_OP_SNZ: begin
        extra_d = (mem_rd_in != 8'h00);
        pc_d    = extra_d ? pc_out + `MIEC_SKIP_STEP : pc_inc;
      end
      `MIEC_OP_SZB: begin
        extra_d = ~bitval;
        pc_d    = extra_d ? pc_out + `MIEC_SKIP_STEP : pc_inc;
      end
      `MIEC_OP_SNZB: begin
        extra_d = bitval;
        pc_d    = extra_d ? pc_out + `MIEC_SKIP_STEP : pc_inc;
      end

      // control transfer; calls push the address after the call
      `MIEC_OP_JMP: pc_d = addr_in;
      `MIEC_OP_CALL: begin
        pc_d   = addr_in;
        push_d = 1'b1;
      end
      `MIEC_OP_RET: begin
        pc_d  = stack_q[sp_q - 2'h1];
        pop_d = 1'b1;
      end
      `MIEC_OP_RETI: begin
        pc_d  = stack_q[sp_q - 2'h1];
        pop_d = 1'b1;
        gie_d = 1'b1;
      end

      // table fetch, and a low pc byte write that keeps the page
      `MIEC_OP_TABRD: tbl_d = table_data_in;
      `MIEC_OP_WRPCL: pc_d = {pc_out[10:8], acc_out};
      // unused codes behave as no operation
      default: pc_d = pc_inc;
    endcase
  end

  // phase counter and instruction sequencing
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_out                   <= `MIEC_PHASE_RST;
      state_q                     <= ST_EXEC;
      pc_out                      <= `MIEC_PC_RST;
      acc_out                     <= `MIEC_BYTE_RST;
      mem_wr_data_out             <= `MIEC_BYTE_RST;
      mem_wr_out                  <= `MIEC_FLAG_RST;
      zero_out                    <= `MIEC_FLAG_RST;
      carry_out                   <= `MIEC_FLAG_RST;
      global_interrupt_enable_out <= `MIEC_FLAG_RST;
      table_latch_out             <= `MIEC_BYTE_RST;
      fetch_out                   <= `MIEC_FLAG_RST;
      stall_out                   <= `MIEC_FLAG_RST;
      sp_q                        <= `MIEC_SP_RST;
      // every stack entry starts at the reset address
      for (k = 0; k < `MIEC_STACK_DEPTH; k = k + 1) begin
        stack_q[k] <= `MIEC_PC_RST;
      end
    end else if (ce_in) begin
      // strobes fall again on the next enabled clock
      phase_out  <= phase_out + 2'h1;
      mem_wr_out <= 1'b0;
      fetch_out  <= 1'b0;
      if (icyc_end) begin
        case (state_q)
          ST_EXEC: begin
            // commit the decoded results at the cycle boundary
            pc_out          <= pc_d;
            acc_out         <= acc_d;
            mem_wr_data_out <= wr_d;
            mem_wr_out      <= wr_en_d;
            zero_out        <= z_d;
            carry_out       <= c_d;
            global_interrupt_enable_out <= gie_d;
            table_latch_out <= tbl_d;
            // subroutine stack push and pop
            if (push_d) begin
              stack_q[sp_q] <= pc_inc;
              sp_q          <= sp_q + 2'h1;
            end
            if (pop_d)
              sp_q <= sp_q - 2'h1;
            // a second cycle holds off the next fetch
            if (extra_d) begin
              state_q   <= ST_WAIT;
              stall_out <= 1'b1;
            end else begin
              fetch_out <= 1'b1;
            end
          end
          ST_WAIT: begin
            // extra cycle over, the next instruction may come
            state_q   <= ST_EXEC;
            stall_out <= 1'b0;
            fetch_out <= 1'b1;
          end
          default: state_q <= ST_EXEC;
        endcase
      end
    end
  end

endmodule

// >>> tb/miec_core_asserts.sv
`include "miec_map.vh"

module miec_core_asserts (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // watched ports
  input wire logic        ce_in,
  input wire logic [4:0]  op_in,
  input wire logic [10:0] pc_out,
  input wire logic [7:0]  acc_out,
  input wire logic        mem_wr_out,
  input wire logic        global_interrupt_enable_out,
  input wire logic        fetch_out,
  input wire logic [1:0]  phase_out,
  input wire logic        stall_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // phase walks 0..3 per enabled clock; the edge that leaves reset
  // is no step, so the sampled reset gates the start
  a_phase_step: assert property (
    rst_n_in && ce_in |=> phase_out == $past(phase_out) + 2'h1)
    else $error("phase step wrong");
  a_fetch_wrap: assert property (fetch_out |-> phase_out == 2'h0)
    else $error("fetch off cycle boundary");
  // extra instruction cycle is exactly four clocks
  a_stall_len: assert property (
    $rose(stall_out) |-> stall_out [*4] ##1 !stall_out)
    else $error("stall length wrong");
  a_stall_fetch: assert property ($fell(stall_out) |-> fetch_out)
    else $error("no fetch after stall");
  a_stall_quiet: assert property (stall_out |-> !fetch_out)
    else $error("fetch during stall");
  // state moves only at execute edge
  a_pc_quiet: assert property (
    ce_in && phase_out != 2'h3 |=> $stable(pc_out))
    else $error("pc moved off execute");
  a_acc_quiet: assert property (
    ce_in && phase_out != 2'h3 |=> $stable(acc_out))
    else $error("acc moved off execute");
  a_wr_pulse: assert property (mem_wr_out |=> !mem_wr_out)
    else $error("write strobe too long");
  a_ie_cause: assert property (
    $rose(global_interrupt_enable_out) |-> $past(op_in) == `MIEC_OP_RETI)
    else $error("enable set without reti");
endmodule

// >>> tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        ce_in = 1'b1;
  logic [4:0]  op_in = 5'h00;
  logic [7:0]  mem_rd_in = 8'h00;
  logic [7:0]  imm_in = 8'h00;
  logic [2:0]  bit_sel_in = 3'h0;
  logic [10:0] addr_in = 11'h000;
  logic [7:0]  table_data_in = 8'h00;
  wire  [10:0] pc_out;
  wire  [7:0]  acc_out, wd_out, tl_out;
  wire         mem_wr_out, zero_out, carry_out, gie_out, fetch_out, stall_out;
  wire  [1:0]  phase_out;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [55:0] r;
  logic [10:0] n, e, s, w;
  logic        g = 1'b0;
  // op, mem, arg, {stall,kind}, value, flags, pc
  logic [55:0] rows [42] = '{
    56'h03_00_080_080_0_001, 56'h04_90_000_010_3_002, 56'h05_11_000_0ff_2_003,
    56'h05_0f_000_0f0_3_004, 56'h06_0f_000_000_c_005, 56'h07_5a_000_05a_8_006,
    56'h08_5a_000_000_c_007, 56'h09_ff_000_100_c_008, 56'h0a_ff_000_100_0_009,
    56'h0b_00_000_1ff_0_00a, 56'h0c_81_000_103_0_00b, 56'h0d_81_000_1c0_0_00c,
    56'h0e_80_000_101_3_00d, 56'h0e_00_000_101_2_00e, 56'h0f_01_000_100_3_00f,
    56'h0f_00_000_180_2_010, 56'h10_00_005_120_0_011, 56'h11_ff_003_1f7_0_012,
    56'h01_3c_000_03c_0_013, 56'h02_00_000_13c_0_014, 56'h12_00_000_700_0_016,
    56'h12_01_000_300_0_017, 56'h13_01_000_700_0_019, 56'h13_00_000_300_0_01a,
    56'h14_04_002_300_0_01b, 56'h14_04_001_700_0_01d, 56'h15_04_002_700_0_01f,
    56'h15_04_000_300_0_020, 56'h16_00_123_700_0_123, 56'h17_00_200_700_0_200,
    56'h00_00_000_300_0_201, 56'h17_00_300_700_0_300, 56'h18_00_000_700_0_202,
    56'h18_00_000_700_0_124, 56'h1a_00_0a5_6a5_0_125, 56'h03_00_040_040_0_126,
    56'h1b_00_000_440_0_140, 56'h17_00_7f0_700_0_7f0, 56'h18_00_000_700_0_141,
    56'h17_00_7f0_700_0_7f0, 56'h19_00_000_700_0_142, 56'h00_00_000_300_0_143
  };

  miec_core DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .op_in(op_in),
    .mem_rd_in(mem_rd_in), .imm_in(imm_in), .bit_sel_in(bit_sel_in),
    .addr_in(addr_in), .table_data_in(table_data_in), .pc_out(pc_out),
    .acc_out(acc_out), .mem_wr_data_out(wd_out), .mem_wr_out(mem_wr_out),
    .zero_out(zero_out), .carry_out(carry_out),
    .global_interrupt_enable_out(gie_out), .table_latch_out(tl_out),
    .fetch_out(fetch_out), .phase_out(phase_out), .stall_out(stall_out)
  );

  // 50 MHz clock
  always #10 clk_in = ~clk_in;

  task automatic chk(input string s, input logic [10:0] v,
                     input logic [10:0] x);
    check_count++;
    if (v !== x) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", s, x, v);
    end
  endtask

  task end_sim;
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // cut a hang short
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      end_sim;
    end
  end

  // run program rows, then freeze and reset cases
  initial begin
    repeat (8) @(posedge clk_in);
    chk("rst", 11'({acc_out, zero_out, carry_out, gie_out}), 11'h000);
    chk("rst pc", pc_out, 11'h000);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      e = 11'(r[23:16]);
      op_in <= r[52:48];
      mem_rd_in <= r[47:40];
      imm_in <= r[35:28];
      bit_sel_in <= r[30:28];
      addr_in <= r[38:28];
      table_data_in <= r[35:28];
      n = 11'h000;
      s = 11'h000;
      do begin
        @(posedge clk_in);
        n++;
        if (stall_out === 1'b1) s++;
      end while (fetch_out !== 1'b1 && n < 11'h014);
      // the first row also waits out the edge that leaves reset
      w = (i == 0) ? 11'h005 : (r[26] ? 11'h008 : 11'h004);
      chk("cycles", n, w);
      chk("stall", s, r[26] ? 11'h004 : 11'h000);
      chk("wr", 11'(mem_wr_out), 11'(r[25:24] == 2'h1));
      chk("pc", pc_out, r[10:0]);
      case (r[25:24])
        2'h0: chk("acc", 11'(acc_out), e);
        2'h1: chk("wdata", 11'(wd_out), e);
        2'h2: chk("table", 11'(tl_out), e);
        default: ;
      endcase
      if (r[15]) chk("zero", 11'(zero_out), 11'(r[14]));
      if (r[13]) chk("carry", 11'(carry_out), 11'(r[12]));
      if (r[52:48] == 5'h19) g = 1'b1;
      chk("gie", 11'(gie_out), 11'(g));
    end
    ce_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk("frozen", {pc_out[8:0], phase_out}, {9'h143, 2'h1});
    ce_in <= 1'b1;
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    chk("rerst", 11'({pc_out[7:0], gie_out}), 11'h000);
    end_sim;
  end
endmodule

bind miec_core miec_core_asserts u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .op_in(op_in),
  .pc_out(pc_out), .acc_out(acc_out), .mem_wr_out(mem_wr_out),
  .global_interrupt_enable_out(global_interrupt_enable_out),
  .fetch_out(fetch_out), .phase_out(phase_out), .stall_out(stall_out)
);
